// file: ecpp_pkg.sv
/*
  Shared constants and types for the ECP peripheral-side parallel port.
  Assumes the pin pad ring resolves the two-way data lines from data_oe.
*/
package ecpp_pkg;

  // Extensibility request values that this port accepts
  localparam logic [7:0] EXT_REQ_ECP    = 8'h10;
  localparam logic [7:0] EXT_REQ_ECP_ID = 8'h14;

  // Depth of the forward byte buffer
  localparam int         FWD_DEPTH      = 2;

  // One byte on the cable plus its command/data flag (1 = command)
  typedef struct packed {
    logic       cmd;
    logic [7:0] data;
  } ecpp_byte_t;

  // Host-driven pins, as seen at the connector
  typedef struct packed {
    logic       host_clk;
    logic       host_ack;
    logic       n_reverse_request;
    logic       active_1284;
    logic [7:0] data;
  } ecpp_host_pins_t;

  // Idle cable levels: strobes high, reverse not requested, port inactive
  localparam ecpp_host_pins_t PINS_IDLE = '{
    host_clk: 1'b1, host_ack: 1'b1, n_reverse_request: 1'b1,
    active_1284: 1'b0, data: 8'h00};

  // Gray codes along forward -> reverse -> strobe -> release
  typedef enum logic [2:0] {
    ST_FWD_IDLE    = 3'h0,
    ST_FWD_BUSY    = 3'h1,
    ST_REV_IDLE    = 3'h3,
    ST_REV_STROBE  = 3'h2,
    ST_REV_RELEASE = 3'h6
  } ecpp_state_t;

endpackage : ecpp_pkg

// file: ecpp_port.sv
/*
  Peripheral end of an ECP-mode parallel port: forward bytes from the host
  into a two-entry buffer, reverse bytes from the user onto the cable.
  Assumes the host keeps the ECP handshake order; all host pins are
  asynchronous and pass a two-stage synchroniser here.
*/
`timescale 1ns/1ps

module ecpp_port (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire ecpp_pkg::ecpp_host_pins_t host_pins,
  output logic [7:0]                     data_out,
  output logic                           data_oe,
  output logic                           periph_clk,
  output logic                           periph_ack,
  output logic                           n_ack_reverse,
  output logic                           xflag,
  output logic                           n_periph_request,
  output logic                           fwd_valid,
  output ecpp_pkg::ecpp_byte_t           fwd_byte,
  input  wire logic                      fwd_ready,
  input  wire logic                      rev_valid,
  input  wire ecpp_pkg::ecpp_byte_t      rev_byte,
  output logic                           rev_ready,
  input  wire logic                      attention,
  input  wire logic                      ext_valid,
  input  wire logic [7:0]                ext_value,
  output logic                           ext_id_mode
);
  import ecpp_pkg::*;

  ecpp_host_pins_t sync1, sync2, next_sync1, next_sync2;
  ecpp_state_t     state, next_state;
  ecpp_byte_t      mem [FWD_DEPTH];
  ecpp_byte_t      next_mem [FWD_DEPTH];
  logic            wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [1:0]      count, next_count;
  ecpp_byte_t      out_byte, next_out_byte;
  logic            ext_ok, next_ext_ok, next_ext_id_mode;
  logic            push, pop, rev_take, full;

  // Synchroniser: stage one feeds stage two only
  always_comb begin
    next_sync1 = sync1;
    next_sync2 = sync2;
    if (ce) begin
      next_sync1 = host_pins;
      next_sync2 = sync1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1 <= PINS_IDLE;
      sync2 <= PINS_IDLE;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
    end
  end

  assign full      = (count == 2'(FWD_DEPTH));
  assign push      = (state == ST_FWD_IDLE) && sync2.active_1284 &&
                     !sync2.host_clk && !full;
  assign pop       = fwd_valid && fwd_ready;
  assign rev_ready = (state == ST_REV_IDLE) && !sync2.host_ack &&
                     sync2.n_reverse_request == 1'b0;
  assign rev_take  = rev_valid && rev_ready;

  // Link state, buffer and reverse byte hold
  always_comb begin
    next_state    = state;
    next_mem      = mem;
    next_wr_ptr   = wr_ptr;
    next_rd_ptr   = rd_ptr;
    next_count    = count;
    next_out_byte = out_byte;
    if (ce) begin
      if (push) begin
        // Host drives low level as 0: data bits stored as seen on the cable, cmd as the inverse of host_ack
        next_mem[wr_ptr] = '{cmd: !sync2.host_ack, data: sync2.data};
        next_wr_ptr      = !wr_ptr;
      end
      if (pop)
        next_rd_ptr = !rd_ptr;
      next_count = count + 2'(push) - 2'(pop);
      case (state)
        ST_FWD_IDLE: begin
          if (push)
            next_state = ST_FWD_BUSY;
          else if (sync2.active_1284 && !sync2.n_reverse_request)
            next_state = ST_REV_IDLE;
        end
        ST_FWD_BUSY: begin
          // Wait for the host to release its strobe before the next byte
          if (sync2.host_clk)
            next_state = ST_FWD_IDLE;
        end
        ST_REV_IDLE: begin
          if (sync2.n_reverse_request)
            next_state = ST_FWD_IDLE;
          else if (rev_take) begin
            next_out_byte = rev_byte;
            next_state    = ST_REV_STROBE;
          end
        end
        ST_REV_STROBE: begin
          if (sync2.host_ack)
            next_state = ST_REV_RELEASE;
        end
        ST_REV_RELEASE: begin
          if (!sync2.host_ack)
            next_state = ST_REV_IDLE;
        end
        default: next_state = ST_FWD_IDLE;
      endcase
      // Leaving ECP mode drops any half-done handshake
      if (!sync2.active_1284)
        next_state = ST_FWD_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state    <= ST_FWD_IDLE;
      mem      <= '{default: '0};
      wr_ptr   <= 1'b0;
      rd_ptr   <= 1'b0;
      count    <= 2'h0;
      out_byte <= '0;
    end else begin
      state    <= next_state;
      mem      <= next_mem;
      wr_ptr   <= next_wr_ptr;
      rd_ptr   <= next_rd_ptr;
      count    <= next_count;
      out_byte <= next_out_byte;
    end
  end

  // Extensibility answer; held until the next ext_valid, even after the host leaves 1284 mode
  always_comb begin
    next_ext_ok      = ext_ok;
    next_ext_id_mode = ext_id_mode;
    if (ce) begin
      if (ext_valid) begin
        next_ext_ok      = (ext_value == EXT_REQ_ECP) ||
                           (ext_value == EXT_REQ_ECP_ID);
        next_ext_id_mode = (ext_value == EXT_REQ_ECP_ID);
      end else if (!sync2.active_1284 && !ext_ok) begin
        next_ext_id_mode = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ext_ok      <= 1'b0;
      ext_id_mode <= 1'b0;
    end else begin
      ext_ok      <= next_ext_ok;
      ext_id_mode <= next_ext_id_mode;
    end
  end

  assign xflag            = ext_ok;
  assign fwd_valid        = (count != 2'h0);
  assign fwd_byte         = mem[rd_ptr];
  assign data_out         = out_byte.data;
  // Only drive the cable once the turnaround is granted
  assign data_oe          = (state == ST_REV_STROBE) ||
                            (state == ST_REV_RELEASE);
  assign n_ack_reverse    = !((state == ST_REV_IDLE) || data_oe);
  assign periph_clk       = (state != ST_REV_STROBE);
  // Busy while a strobe is pending or the buffer has no room; while data_oe is high it carries the inverse of cmd
  assign periph_ack       = data_oe ? !out_byte.cmd
                                    : ((state == ST_FWD_BUSY) || full);
  assign n_periph_request = !(attention || rev_valid);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || !ce);

  sequence s_rev_req;
    state == ST_FWD_IDLE && !push && sync2.active_1284 &&
    !sync2.n_reverse_request;
  endsequence

  sequence s_rev_send;
    rev_take ##1 (!periph_clk && data_oe);
  endsequence

  property p_grant;
    s_rev_req |=> !n_ack_reverse;
  endproperty
  a_grant: assert property (p_grant)
    else $error("reverse request not granted");

  // The grant must already have stood a cycle before the pads turn round
  property p_oe_after_grant;
    data_oe |-> !n_ack_reverse && !$past(n_ack_reverse);
  endproperty
  a_oe_after_grant: assert property (p_oe_after_grant)
    else $error("data driven without reverse grant");

  property p_rev_strobe;
    rev_take |=> !periph_clk && data_out == $past(rev_byte.data) &&
                 periph_ack == !$past(rev_byte.cmd);
  endproperty
  a_rev_strobe: assert property (p_rev_strobe)
    else $error("reverse byte not strobed with its flag");

  property p_rev_hold;
    s_rev_send ##0 !sync2.host_ack |=> !periph_clk && $stable(data_out);
  endproperty
  a_rev_hold: assert property (p_rev_hold)
    else $error("reverse strobe released before host answered");

  property p_full_throttle;
    !data_oe && full |-> periph_ack;
  endproperty
  a_full_throttle: assert property (p_full_throttle)
    else $error("forward not throttled while buffer full");

  property p_fwd_capture;
    push |=> fwd_valid && mem[$past(wr_ptr)].data == $past(sync2.data) &&
             periph_ack;
  endproperty
  a_fwd_capture: assert property (p_fwd_capture)
    else $error("forward byte not captured as sampled");

  property p_ext_ecp;
    ext_valid && ext_value == EXT_REQ_ECP |=> xflag && !ext_id_mode;
  endproperty
  a_ext_ecp: assert property (p_ext_ecp)
    else $error("ECP request not accepted");

  property p_ext_id;
    ext_valid && ext_value == EXT_REQ_ECP_ID |=> xflag && ext_id_mode;
  endproperty
  a_ext_id: assert property (p_ext_id)
    else $error("device ID request not accepted");

  property p_attention;
    rev_valid || attention |-> !n_periph_request;
  endproperty
  a_attention: assert property (p_attention)
    else $error("host request not raised");

endmodule : ecpp_port

// file: ecpp_host_model.sv
/*
  Host side of the ECP cable, driven through tasks called by the bench.
  Assumes every task is entered at a falling edge of sys_clk.
*/
`timescale 1ns/1ps
module ecpp_host_model (
  input  wire logic             sys_clk,
  input  wire logic [7:0]       data_out,
  input  wire logic             data_oe,
  input  wire logic             periph_clk,
  input  wire logic             periph_ack,
  input  wire logic             n_ack_reverse,
  output ecpp_pkg::ecpp_host_pins_t host_pins
);
  import ecpp_pkg::*;
  ecpp_host_pins_t drv = PINS_IDLE;
  logic            own = 1'b1;
  // Released lines show the inverse of the last value, never a stale copy
  always_comb begin
    host_pins = drv;
    host_pins.data = data_oe ? data_out : (own ? drv.data : ~drv.data);
  end
  initial begin
    repeat (8) @(negedge sys_clk);
    drv.active_1284 = 1'b1;
  end
  function automatic logic pick(input int s);
    return s == 0 ? periph_ack :
           (s == 1 ? periph_clk : (s == 2 ? n_ack_reverse : data_oe));
  endfunction : pick
  task automatic wt(input int s, input logic v, inout bit ok);
    for (int i = 0; i < 400 && pick(s) !== v; i++) @(negedge sys_clk);
    if (pick(s) !== v) ok = 1'b0;
  endtask : wt
  task automatic fwd(input ecpp_byte_t b, inout bit ok);
    wt(0, 1'b0, ok);
    drv.data = b.data;
    drv.host_ack = ~b.cmd;
    @(negedge sys_clk);
    drv.host_clk = 1'b0;
    wt(0, 1'b1, ok);
    drv.host_clk = 1'b1;
    @(negedge sys_clk);
  endtask : fwd
  task automatic turn(input logic req, inout bit ok);
    own = ~req;
    drv.n_reverse_request = ~req;
    wt(2, ~req, ok);
  endtask : turn
  task automatic take(output ecpp_byte_t b, inout bit ok);
    drv.host_ack = 1'b0;
    wt(1, 1'b0, ok);
    b.data = host_pins.data;
    b.cmd = ~periph_ack;
    drv.host_ack = 1'b1;
    wt(1, 1'b1, ok);
    // Closing the host_ack cycle lets the port leave its release phase
    drv.host_ack = 1'b0;
    wt(3, 1'b0, ok);
  endtask : take
endmodule : ecpp_host_model

// file: ecpp_port_tb.sv
/*
  Self-checking bench for the ECP peripheral port against a host model.
  Assumes the host model keeps the cable handshake order.
*/
`timescale 1ns/1ps
module ecpp_port_tb;
  import ecpp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic fwd_ready = 1'b0;
  logic rev_valid = 1'b0;
  logic attention = 1'b0;
  logic ext_valid = 1'b0;
  logic [7:0] ext_value = 8'h00;
  ecpp_byte_t rev_byte = '0;
  ecpp_byte_t fwd_byte, b;
  ecpp_host_pins_t host_pins;
  logic [7:0] data_out;
  logic data_oe, periph_clk, periph_ack, n_ack_reverse, xflag;
  logic n_periph_request, fwd_valid, rev_ready, ext_id_mode;
  ecpp_byte_t q[$];
  ecpp_byte_t hq[$];
  int num_errors = 0;
  int checked = 0;
  int n;
  bit ok = 1'b1;
  ecpp_port ecpp_port_inst (.sys_clk, .rst, .ce, .host_pins,
    .data_out, .data_oe, .periph_clk, .periph_ack, .n_ack_reverse, .xflag,
    .n_periph_request, .fwd_valid, .fwd_byte, .fwd_ready, .rev_valid,
    .rev_byte, .rev_ready, .attention, .ext_valid, .ext_value,
    .ext_id_mode);
  ecpp_host_model ecpp_host_model_inst (.sys_clk, .data_out, .data_oe,
    .periph_clk, .periph_ack, .n_ack_reverse, .host_pins);
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  function automatic logic npr(input logic a, input logic v);
    return ~(a | v);
  endfunction : npr
  task automatic close_out;
    if (num_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic sure;
    if (!ok) begin
      num_errors++;
      close_out;
    end
  endtask : sure
  initial begin
    void'($urandom(32'h33845EF5));
    repeat (6) @(negedge sys_clk);
    chk({periph_clk, n_ack_reverse, periph_ack, data_oe, xflag, fwd_valid,
      rev_ready, n_periph_request, ext_id_mode}, 9'h182);
    rst = 1'b0;
    repeat (10) @(negedge sys_clk);
    // A request offered while the enable is low must leave no trace
    ce = 1'b0;
    ext_value = 8'h10;
    ext_valid = 1'b1;
    @(negedge sys_clk);
    ext_valid = 1'b0;
    ce = 1'b1;
    chk(xflag, 1'b0);
    for (int k = 0; k < 3; k++) begin
      ext_value = k == 0 ? 8'h14 :
                  (k == 1 ? 8'h10 : 8'h20 | 8'($urandom_range(15, 0)));
      ext_valid = 1'b1;
      @(negedge sys_clk);
      ext_valid = 1'b0;
      chk({xflag, ext_id_mode}, {k < 2, k == 0});
    end
    attention = 1'b1;
    @(negedge sys_clk);
    chk(n_periph_request, npr(1'b1, 1'b0));
    attention = 1'b0;
    fork
      for (int k = 0; k < 6; k++) begin
        b = ecpp_byte_t'(9'($urandom));
        q.push_back(b);
        ecpp_host_model_inst.fwd(b, ok);
      end
    join_none
    repeat (150) @(negedge sys_clk);
    chk({fwd_valid, periph_ack}, 9'h003);
    n = 0;
    for (int i = 0; i < 800 && n < 6; i++) begin
      fwd_ready = 1'($urandom_range(1, 0));
      if (fwd_valid && fwd_ready) begin
        chk(fwd_byte, q.pop_front());
        n++;
      end
      @(negedge sys_clk);
    end
    fwd_ready = 1'b0;
    ok = ok && n == 6;
    sure;
    ecpp_host_model_inst.turn(1'b1, ok);
    sure;
    chk({n_ack_reverse, data_oe}, 9'h000);
    fork
      for (int k = 0; k < 3; k++) begin
        ecpp_host_model_inst.take(b, ok);
        hq.push_back(b);
      end
      for (int k = 0; k < 3; k++) begin
        @(negedge sys_clk);
        rev_byte = ecpp_byte_t'(9'($urandom));
        q.push_back(rev_byte);
        rev_valid = 1'b1;
        #1 chk(n_periph_request, npr(1'b0, 1'b1));
        for (int i = 0; i < 400 && !rev_ready; i++) @(negedge sys_clk);
        if (!rev_ready) begin
          num_errors++;
          close_out;
        end
        @(negedge sys_clk);
        rev_valid = 1'b0;
      end
    join
    sure;
    foreach (q[k]) chk(hq[k], q[k]);
    ecpp_host_model_inst.turn(1'b0, ok);
    sure;
    chk(n_ack_reverse, 1'b1);
    close_out;
  end
endmodule : ecpp_port_tb
